// >>> logic/scl_map.vh
// constants and field layout of the station configuration loader
//
// Function
// - selector 01 is master, 02..99 slave, 00 is an invalid setting
// - a selector address overrides the software-written station address
// - a new selector address is applied only after a one-second button hold
// - addresses 100..250 come only from the software-written configuration or a six-second stick read
// - radio link allowed only to peers with an equal network identifier
// - key module gives identifier and band; software cannot then write identifier
// - software band must be 1..8, software identifier 1..127
// - six-second hold without stick enters save mode with a rising LED chase
// - stick inserted in save mode starts the write; chase stops when done
// - a save writes the shared network set and the per-station set
// - stick present, 1..6 s press reads shared set, data LED pulses once
// - stick present, six-second hold reads both sets, data LED flashes meanwhile
// - a stick image from newer firmware than ours is refused
// - errors while saving or checking flash data and error LEDs together
`ifndef SCL_MAP_VH
`define SCL_MAP_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define SCL_CLK_HZ 100000000
`define SCL_DEBOUNCE_MS 10
`define SCL_SHORT_HOLD_S 1
`define SCL_LONG_HOLD_S 6
`define SCL_BLINK_MS 125
`define SCL_PULSE_MS 250

// ----------------------------------------
// parameter image word index
// ----------------------------------------
`define SCL_W_VERSION 4'h0
`define SCL_W_MODE 4'h1
`define SCL_W_NETWORK_IDENTIFIER 4'h2
`define SCL_W_BAND 4'h3
`define SCL_W_RATE 4'h4
`define SCL_W_CRYPT 4'h5
`define SCL_W_NET_TYPE 4'h6
`define SCL_W_NAME 4'h7
`define SCL_W_ADDR 4'h8
`define SCL_W_TX_POWER 4'h9
`define SCL_W_ALLOW 4'ha
`define SCL_W_SERIAL 4'hb
`define SCL_W_LAST 4'hb

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define SCL_RST_NETWORK_IDENTIFIER 8'h7f
`define SCL_RST_BAND 8'h01
`define SCL_RST_OTHER 8'h00
`define SCL_NETWORK_IDENTIFIER_MAX 8'h7f
`define SCL_BAND_MAX 8'h08
`define SCL_ADDR_MAX 8'hfa
`define SCL_ADDR_MASTER 8'h01

`endif

// >>> logic/scl_loader.v
// station configuration loader: selector, set button, key and memory stick
`timescale 1ns/10ps
`default_nettype none
`include "scl_map.vh"

module scl_loader #(
  parameter DEBOUNCE_CYCLES = `SCL_DEBOUNCE_MS * (`SCL_CLK_HZ / 1000),
  parameter SHORT_HOLD_CYCLES = `SCL_SHORT_HOLD_S * `SCL_CLK_HZ,
  parameter LONG_HOLD_CYCLES = `SCL_LONG_HOLD_S * `SCL_CLK_HZ,
  parameter BLINK_CYCLES = `SCL_BLINK_MS * (`SCL_CLK_HZ / 1000),
  parameter PULSE_CYCLES = `SCL_PULSE_MS * (`SCL_CLK_HZ / 1000),
  // arbitrary value
  parameter [7:0] FW_VERSION = 8'h10
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [3:0] selector_tens,
  input wire [3:0] selector_ones,
  input wire set_button,
  input wire stick_present,
  input wire stick_is_key,
  output reg mem_req,
  output reg mem_write,
  output reg [3:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire mem_ack,
  input wire mem_error,
  input wire sw_wr,
  input wire [3:0] sw_sel,
  input wire [7:0] sw_wdata,
  output reg sw_write_refused,
  input wire [3:0] param_sel,
  output reg [7:0] param_rdata,
  input wire peer_valid,
  input wire [6:0] peer_network_identifier,
  output reg link_permit,
  output reg [7:0] station_address,
  output reg station_is_master,
  output reg selector_invalid,
  output reg [6:0] network_identifier,
  output reg [3:0] frequency_band,
  output reg [3:0] rssi_led,
  output reg data_activity_led,
  output reg error_led,
  output reg busy
);

  localparam ST_IDLE = 3'h0;
  localparam ST_SAVE_WAIT = 3'h1;
  localparam ST_XFER = 3'h2;
  localparam ST_COMMIT = 3'h3;
  localparam ST_PULSE = 3'h4;
  localparam ST_ERROR = 3'h5;

  localparam OP_SAVE = 2'h0;
  localparam OP_SHARED = 2'h1;
  localparam OP_FULL = 2'h2;
  localparam OP_KEY = 2'h3;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [7:0] last_word;
    input [1:0] op;
    begin
      case (op)
        OP_SHARED: last_word = {4'h0, `SCL_W_NET_TYPE};
        OP_KEY: last_word = {4'h0, `SCL_W_BAND};
        default: last_word = {4'h0, `SCL_W_LAST};
      endcase
    end
  endfunction

  // software write is refused: value outside its legal range, identifier locked by the key, or word not writable
  function sw_bad;
    input [3:0] sel;
    input [7:0] val;
    input locked;
    begin
      case (sel)
        `SCL_W_NETWORK_IDENTIFIER: sw_bad = locked || val == 8'h00 ||
          val > `SCL_NETWORK_IDENTIFIER_MAX;
        `SCL_W_BAND: sw_bad = val == 8'h00 || val > `SCL_BAND_MAX;
        `SCL_W_ADDR: sw_bad = val == 8'h00 || val > `SCL_ADDR_MAX;
        default: sw_bad = sel > `SCL_W_LAST || sel == `SCL_W_VERSION;
      endcase
    end
  endfunction

  reg [7:0] par [0:11];
  reg [7:0] stage [0:11];
  reg [2:0] state;
  reg [1:0] op;
  reg [3:0] ptr;
  reg key_locked;
  reg sel_valid;
  reg [7:0] sel_addr;
  reg btn;
  reg [31:0] deb_cnt;
  reg [31:0] hold_cnt;
  reg long_done;
  reg [31:0] blink_cnt;
  reg blink;
  reg [1:0] chase;
  reg [31:0] pulse_cnt;
  integer i;

  wire [7:0] sel_bin = {4'h0, selector_tens} * 8'd10 + {4'h0, selector_ones};
  wire sel_digits_ok = selector_tens < 4'ha && selector_ones < 4'ha;
  wire btn_release = btn && deb_cnt == DEBOUNCE_CYCLES - 1 && !set_button;
  wire btn_press = !btn && deb_cnt == DEBOUNCE_CYCLES - 1 && set_button;
  wire long_hit = btn && !long_done && hold_cnt == LONG_HOLD_CYCLES - 1;
  wire short_ok = hold_cnt >= SHORT_HOLD_CYCLES - 1 && !long_done;
  wire is_last = {4'h0, ptr} == last_word(op);

  // ----------------------------------------
  // button debounce and hold timer
  // ----------------------------------------
  // the raw level must hold for the whole window before it is believed
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      btn <= 1'b0;
      deb_cnt <= 32'h0;
      hold_cnt <= 32'h0;
      long_done <= 1'b0;
    end else begin
      if (set_button == btn) begin
        deb_cnt <= 32'h0;
      end else if (deb_cnt == DEBOUNCE_CYCLES - 1) begin
        deb_cnt <= 32'h0;
        btn <= set_button;
      end else begin
        deb_cnt <= deb_cnt + 32'h1;
      end
      if (!btn) begin
        hold_cnt <= 32'h0;
        long_done <= 1'b0;
      end else if (long_hit) begin
        long_done <= 1'b1;
      end else if (!long_done) begin
        hold_cnt <= hold_cnt + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // blink and chase timebase
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      blink_cnt <= 32'h0;
      blink <= 1'b0;
      chase <= 2'h0;
    end else if (blink_cnt == BLINK_CYCLES - 1) begin
      blink_cnt <= 32'h0;
      blink <= !blink;
      chase <= chase + 2'h1;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // ----------------------------------------
  // sequencer, parameter store, stick transfers
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      op <= OP_SAVE;
      ptr <= 4'h0;
      key_locked <= 1'b0;
      sel_valid <= 1'b0;
      sel_addr <= 8'h00;
      selector_invalid <= 1'b0;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= 4'h0;
      mem_wdata <= 8'h00;
      sw_write_refused <= 1'b0;
      pulse_cnt <= 32'h0;
      for (i = 0; i < 12; i = i + 1) begin
        par[i] <= `SCL_RST_OTHER;
        stage[i] <= `SCL_RST_OTHER;
      end
      par[`SCL_W_NETWORK_IDENTIFIER] <= `SCL_RST_NETWORK_IDENTIFIER;
      par[`SCL_W_BAND] <= `SCL_RST_BAND;
    end else begin
      sw_write_refused <= 1'b0;
      // software writes are refused when sw_bad holds, and in the commit cycle while stick data is copied into the store
      if (sw_wr) begin
        if (sw_bad(sw_sel, sw_wdata, key_locked) || state == ST_COMMIT) begin
          sw_write_refused <= 1'b1;
        end else begin
          par[sw_sel] <= sw_wdata;
        end
      end
      case (state)
        ST_IDLE: begin
          if (long_hit && !stick_present) begin
            state <= ST_SAVE_WAIT;
          end else if (long_hit && !stick_is_key) begin
            op <= OP_FULL;
            ptr <= `SCL_W_VERSION;
            state <= ST_XFER;
          end else if (btn_release && short_ok) begin
            if (!stick_present) begin
              // selector value latched only here
              if (!sel_digits_ok || sel_bin == 8'h00) begin
                selector_invalid <= 1'b1;
                sel_valid <= 1'b0;
              end else begin
                selector_invalid <= 1'b0;
                sel_valid <= 1'b1;
                sel_addr <= sel_bin;
              end
            end else if (stick_is_key) begin
              op <= OP_KEY;
              ptr <= `SCL_W_NETWORK_IDENTIFIER;
              state <= ST_XFER;
            end else begin
              op <= OP_SHARED;
              ptr <= `SCL_W_VERSION;
              state <= ST_XFER;
            end
          end
        end
        ST_SAVE_WAIT: begin
          if (stick_present && !stick_is_key) begin
            op <= OP_SAVE;
            ptr <= `SCL_W_VERSION;
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (!stick_present) begin
            mem_req <= 1'b0;
            state <= ST_ERROR;
          end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_write <= op == OP_SAVE;
            mem_addr <= ptr;
            mem_wdata <= ptr == `SCL_W_VERSION ? FW_VERSION : par[ptr];
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            if (mem_error) begin
              state <= ST_ERROR;
            end else if (op != OP_SAVE && ptr == `SCL_W_VERSION &&
                         mem_rdata > FW_VERSION) begin
              state <= ST_ERROR;
            end else begin
              stage[ptr] <= mem_rdata;
              if (is_last) begin
                state <= op == OP_SAVE ? ST_IDLE : ST_COMMIT;
              end else begin
                ptr <= ptr + 4'h1;
              end
            end
          end
        end
        ST_COMMIT: begin
          for (i = 1; i < 12; i = i + 1) begin
            if (i <= last_word(op) && (op != OP_KEY ||
                i == `SCL_W_NETWORK_IDENTIFIER || i == `SCL_W_BAND)) begin
              par[i] <= stage[i];
            end
          end
          if (op == OP_KEY) begin
            key_locked <= 1'b1;
          end
          pulse_cnt <= 32'h0;
          state <= op == OP_FULL ? ST_IDLE : ST_PULSE;
        end
        ST_PULSE: begin
          if (pulse_cnt == PULSE_CYCLES - 1) begin
            state <= ST_IDLE;
          end else begin
            pulse_cnt <= pulse_cnt + 32'h1;
          end
        end
        ST_ERROR: begin
          // held until the user acknowledges with a fresh press
          if (btn_press) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      station_address <= 8'h00;
      station_is_master <= 1'b0;
      network_identifier <= 7'h7f;
      frequency_band <= 4'h1;
      link_permit <= 1'b0;
      param_rdata <= 8'h00;
      rssi_led <= 4'h0;
      data_activity_led <= 1'b0;
      error_led <= 1'b0;
      busy <= 1'b0;
    end else begin
      station_address <= sel_valid ? sel_addr : par[`SCL_W_ADDR];
      station_is_master <= sel_valid ? sel_addr == `SCL_ADDR_MASTER :
        par[`SCL_W_ADDR] == `SCL_ADDR_MASTER;
      network_identifier <= par[`SCL_W_NETWORK_IDENTIFIER][6:0];
      frequency_band <= par[`SCL_W_BAND][3:0];
      link_permit <= peer_valid &&
        peer_network_identifier == par[`SCL_W_NETWORK_IDENTIFIER][6:0];
      param_rdata <= param_sel > `SCL_W_LAST ? 8'h00 : par[param_sel];
      rssi_led <= (state == ST_SAVE_WAIT ||
        (state == ST_XFER && op == OP_SAVE)) ? 4'h1 << chase : 4'h0;
      data_activity_led <= state == ST_PULSE ||
        (state == ST_XFER && op == OP_FULL && blink) ||
        (state == ST_ERROR && blink);
      error_led <= state == ST_ERROR && blink;
      busy <= state != ST_IDLE;
    end
  end

endmodule
`default_nettype wire

// >>> sim/scl_mem_model.sv
// behavioural plug-in memory stick on the service port
`timescale 1ns/10ps
`default_nettype none
module scl_mem_model (
  input wire logic sys_clk,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [3:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [3:0] lat,
  input wire logic err_inj,
  output var logic [7:0] mem_rdata,
  output var logic mem_ack,
  output var logic mem_error
);
  logic [7:0] mem [0:11];
  int cnt = 0;
  initial begin
    mem_ack = 1'b0;
    mem_error = 1'b0;
    mem_rdata = 8'h00;
  end
  always @(posedge sys_clk) begin
    mem_ack <= 1'b0;
    mem_error <= 1'b0;
    // read data does not linger once the answer is gone
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (cnt < lat) begin
        cnt <= cnt + 1;
      end else begin
        cnt <= 0;
        mem_ack <= 1'b1;
        mem_error <= err_inj;
        if (mem_write) begin
          mem[mem_addr] <= mem_wdata;
        end else begin
          mem_rdata <= mem[mem_addr];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/scl_loader_assertions.sv
// concurrent checks on the ports of the configuration loader
`timescale 1ns/10ps
`default_nettype none
module scl_loader_assertions (
  input wire sys_clk,
  input wire rst_b,
  input wire mem_req,
  input wire mem_ack,
  input wire mem_write,
  input wire [3:0] mem_addr,
  input wire stick_present,
  input wire sw_wr,
  input wire sw_write_refused,
  input wire peer_valid,
  input wire [6:0] peer_network_identifier,
  input wire link_permit,
  input wire [6:0] network_identifier,
  input wire [7:0] station_address,
  input wire [3:0] frequency_band,
  input wire [3:0] rssi_led,
  input wire data_activity_led,
  input wire error_led
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // the identifier output and the permit both lag the stored value by one
  link_match_a: assert property ($past(rst_b) |-> link_permit ==
    ($past(peer_valid) && $past(peer_network_identifier) ==
    network_identifier)) else $error("link permit wrong");
  refuse_cause_a: assert property (sw_write_refused |-> $past(sw_wr))
    else $error("refusal without write");
  band_range_a: assert property (frequency_band != 4'h0
    && frequency_band <= 4'h8) else $error("band out of range");
  addr_range_a: assert property (station_address <= 8'hfa)
    else $error("address above limit");
  chase_onehot_a: assert property ($onehot0(rssi_led))
    else $error("chase not one hot");
  save_chase_a: assert property (mem_req && mem_write |->
    rssi_led != 4'h0) else $error("write without chase");
  err_together_a: assert property (error_led |-> data_activity_led)
    else $error("error led alone");
  req_hold_a: assert property (mem_req && !mem_ack && stick_present
    |=> mem_req && $stable(mem_addr) && $stable(mem_write))
    else $error("request not held");
  req_drop_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("request not dropped");
  save_c: cover property (mem_req && mem_write && mem_ack);
  read_c: cover property (mem_req && !mem_write && mem_ack);
  error_c: cover property (error_led);
endmodule
bind scl_loader scl_loader_assertions chk (.*);
`default_nettype wire

// >>> sim/scl_loader_tb_top.sv
// self-checking testbench of the configuration loader
`timescale 1ns/10ps
`default_nettype none
module scl_loader_tb_top;
  logic sys_clk = 0;
  logic rst_b = 0;
  logic [3:0] st = 0, so = 0, sw_sel = 0, param_sel = 0, lat = 0;
  logic btn = 0, sp = 0, key = 0, sw_wr = 0, pv = 0, led_q = 0, ierr = 0;
  logic [7:0] sw_wdata = 0;
  logic [6:0] pid = 0;
  wire mem_req, mem_write, mem_ack, mem_error, refused, link, master;
  wire inval, data_led, err_led, busy;
  wire [3:0] mem_addr, band, rssi;
  wire [7:0] mem_wdata, mem_rdata, prd, addr;
  wire [6:0] nid;
  int err_total = 0, total_checks = 0, rises = 0, r0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    led_q <= data_led;
    if (data_led && !led_q) rises <= rises + 1;
  end
  scl_loader #(.DEBOUNCE_CYCLES(4), .SHORT_HOLD_CYCLES(50),
    .LONG_HOLD_CYCLES(300), .BLINK_CYCLES(4), .PULSE_CYCLES(8)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .selector_tens(st),
    .selector_ones(so), .set_button(btn), .stick_present(sp),
    .stick_is_key(key), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .mem_error(mem_error), .sw_wr(sw_wr),
    .sw_sel(sw_sel), .sw_wdata(sw_wdata), .sw_write_refused(refused),
    .param_sel(param_sel), .param_rdata(prd), .peer_valid(pv),
    .peer_network_identifier(pid), .link_permit(link),
    .station_address(addr), .station_is_master(master),
    .selector_invalid(inval), .network_identifier(nid),
    .frequency_band(band), .rssi_led(rssi),
    .data_activity_led(data_led), .error_led(err_led), .busy(busy));
  scl_mem_model mdl (.sys_clk(sys_clk), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .lat(lat), .err_inj(ierr), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .mem_error(mem_error));
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // debounce delays press and release alike, so hold length is about n
  task automatic press(input int n);
    btn = 1;
    cyc(n);
    btn = 0;
    cyc(12);
  endtask
  task automatic idle;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) cyc(1);
    chk("busy", 0, busy);
  endtask
  task automatic sw(input logic [3:0] s, input logic [7:0] d, input r);
    sw_sel = s;
    sw_wdata = d;
    sw_wr = 1;
    cyc(1);
    chk("refused", r, refused);
    sw_wr = 0;
    cyc(2);
  endtask
  task automatic t_sel;
    press(100);
    chk("invalid", 1, inval);
    st = 9;
    so = 9;
    cyc(5);
    chk("addr held", 0, addr);
    press(100);
    chk("addr", 8'h63, addr);
    chk("slave", 0, master);
    st = 0;
    so = 1;
    press(100);
    chk("master", 1, master);
  endtask
  task automatic t_sw;
    sw(3, 0, 1);
    sw(3, 9, 1);
    sw(3, 8, 0);
    sw(2, 0, 1);
    sw(2, 8'h80, 1);
    sw(2, 8'h7e, 0);
    sw(8, 8'hfb, 1);
    sw(8, 8'hfa, 0);
    sw(0, 1, 1);
    sw(4'hc, 1, 1);
    param_sel = 8;
    cyc(2);
    chk("sw addr", 8'hfa, prd);
    chk("addr", 1, addr);
    chk("band", 8, band);
    chk("id", 8'h7e, nid);
  endtask
  task automatic t_save;
    for (int i = 0; i < 12; i++) mdl.mem[i] = 8'hff;
    press(400);
    chk("chase", 1, rssi != 4'h0);
    sp = 1;
    idle;
    chk("chase off", 0, rssi);
    chk("ver", 8'h10, mdl.mem[0]);
    chk("id", 8'h7e, mdl.mem[2]);
    chk("band", 8, mdl.mem[3]);
    chk("serial", 0, mdl.mem[11]);
  endtask
  task automatic t_full;
    mdl.mem[2] = 8'h11;
    mdl.mem[3] = 5;
    mdl.mem[8] = 7;
    lat = 3;
    r0 = rises;
    press(400);
    idle;
    chk("flashes", 1, rises - r0 > 1);
    chk("id", 8'h11, nid);
    chk("band", 5, band);
    chk("par addr", 7, prd);
    chk("led off", 0, data_led);
  endtask
  task automatic t_short;
    mdl.mem[0] = 8'h0f;
    mdl.mem[3] = 6;
    mdl.mem[8] = 9;
    r0 = rises;
    press(100);
    idle;
    cyc(20);
    chk("one pulse", 1, rises - r0);
    chk("band", 6, band);
    chk("par addr", 7, prd);
  endtask
  // error led blinks, so look over several blink periods
  task automatic flash_chk;
    logic e;
    e = 0;
    for (int i = 0; i < 20; i++) begin
      cyc(1);
      e = e | err_led;
    end
    chk("error", 1, e);
  endtask
  task automatic t_ver;
    mdl.mem[0] = 8'h11;
    mdl.mem[3] = 2;
    press(100);
    flash_chk;
    chk("band", 6, band);
    mdl.mem[0] = 8'h10;
    ierr = 1;
    press(100);
    flash_chk;
    chk("band kept", 6, band);
    ierr = 0;
    press(100);
    idle;
    cyc(20);
    chk("error off", 0, err_led);
    chk("band", 2, band);
  endtask
  task automatic t_key;
    key = 1;
    mdl.mem[2] = 8'h2a;
    mdl.mem[3] = 3;
    press(100);
    idle;
    chk("id", 8'h2a, nid);
    chk("band", 3, band);
    sw(2, 5, 1);
    pv = 1;
    pid = 7'h2a;
    cyc(2);
    chk("link", 1, link);
    pid = 7'h2b;
    cyc(2);
    chk("link", 0, link);
  endtask
  initial begin
    cyc(3);
    rst_b = 1;
    cyc(1);
    chk("id", 8'h7f, nid);
    chk("band", 1, band);
    t_sel;
    t_sw;
    t_save;
    t_full;
    t_short;
    t_ver;
    t_key;
    results;
  end
  // whole run needs about two thousand cycles
  initial begin
    #50us;
    err_total++;
    results;
  end
endmodule
`default_nettype wire
